// [rtl/cfg_pkg.sv]
// Shared constants, types and states for the two-wire configuration port.
package cfg_pkg;
   // Fixed upper slave address bits; the straps supply the low three.
   localparam logic [3:0] ADDR_FIXED = 4'hb;
   // Three-level strap decode: each strap arrives as a two-bit level code.
   localparam logic [1:0] STRAP_LOW = 2'h0;
   localparam logic [1:0] STRAP_OPEN = 2'h1;
   localparam logic [1:0] STRAP_HIGH = 2'h2;
   localparam logic [1:0] STRAP_SETTLE = 2'h3;
   // Register address that commits the shadow buffer, and its self-clearing bit.
   localparam logic [15:0] UPDATE_ADDR = 16'h0232;
   localparam logic [7:0] UPDATE_MASK = 8'h01;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   // Byte position in a transfer: slave address, pointer high, pointer low, data.
   localparam logic [1:0] BYTE_SLAVE = 2'h0;
   localparam logic [1:0] BYTE_PTR_HI = 2'h1;
   localparam logic [1:0] BYTE_PTR_LO = 2'h2;
   localparam logic [1:0] BYTE_DATA = 2'h3;
   // Serial clock rates served, and the link sampling clock that covers them.
   localparam int STD_SCL_HZ = 100000;
   localparam int FAST_SCL_HZ = 400000;
   localparam int LINK_CLK_HZ = 8000000;
   localparam int LINK_PER_SCL = LINK_CLK_HZ / FAST_SCL_HZ;

   typedef struct packed {
      logic [1:0] upper;
      logic [1:0] lower;
   } strap_t;

   typedef struct packed {
      logic scl;
      logic sda;
   } line_t;

   typedef struct packed {
      logic write;
      logic [15:0] addr;
      logic [7:0] data;
   } req_t;

   typedef enum logic [2:0] {ST_IDLE, ST_RECV, ST_ACK, ST_SEND, ST_WACK} state_t;
endpackage

// [rtl/config_store.sv]
// Shadow and active configuration bytes with the commit-on-update behaviour.
module config_store #(
   parameter int AW = 10
) (
   input wire logic clock,          // System clock.
   input wire logic resetn,         // Asynchronous reset, active low.
   input wire logic wr_en,          // One-cycle write strobe.
   input wire logic [15:0] wr_addr, // Write register address.
   input wire logic [7:0] wr_data,  // Write data.
   input wire logic [15:0] rd_addr, // Read register address.
   output logic [7:0] rd_data,      // Shadow byte at rd_addr.
   input wire logic [15:0] cfg_addr,// Active byte lookup address.
   output logic [7:0] cfg_data      // Active byte, registered.
);
   import cfg_pkg::*;

   logic [7:0] shadow_mem [2**AW];
   logic [7:0] active_mem [2**AW];
   logic is_update;
   logic do_update;

   assign is_update = wr_addr == UPDATE_ADDR;
   assign do_update = wr_en && is_update && |(wr_data & UPDATE_MASK);
   assign rd_data = shadow_mem[rd_addr[AW-1:0]];

   // The update bit is never stored, so it reads back as zero.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < 2**AW; i++) shadow_mem[i] <= 8'h00;
      end else if (wr_en) begin
         shadow_mem[wr_addr[AW-1:0]] <= is_update ? (wr_data & ~UPDATE_MASK) : wr_data;
      end
   end

   // All buffered bytes become active together on an update.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < 2**AW; i++) active_mem[i] <= 8'h00;
      end else if (do_update) begin
         for (int i = 0; i < 2**AW; i++) active_mem[i] <= shadow_mem[i];
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) cfg_data <= 8'h00;
      else cfg_data <= active_mem[cfg_addr[AW-1:0]];
   end

   property p_plain_write_keeps_active;
      @(posedge clock) disable iff (!resetn)
      (wr_en && !do_update) |=> active_mem[$past(wr_addr[AW-1:0])] == $past(active_mem[wr_addr[AW-1:0]]);
   endproperty
   a_plain_write_keeps_active: assert property (p_plain_write_keeps_active)
      else $error("active byte changed without an update");
endmodule

// [rtl/level_sync.sv]
// Two-flop synchroniser for levels entering a clock domain.
module level_sync #(
   parameter int W = 1
) (
   input wire logic clock,        // Destination clock.
   input wire logic resetn,       // Destination reset, active low.
   input wire logic [W-1:0] d,    // Asynchronous level.
   output logic [W-1:0] q         // Synchronised level.
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         meta_reg <= '0;
         q <= '0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule

// [rtl/two_wire_config_port_slave.sv]
// Two-wire configuration port slave with strap-selected address and register store.
// Contract
// - Four-wire port only when both straps are high; else the two-wire port.
// - Slave address upper four bits are fixed at 1011.
// - Strap pairs, upper major, give low address bits 000 to 111.
// - Works at both 100 kHz and 400 kHz serial clock.
// - Slave only; never drives the serial clock line.
// - Register address is two bytes, a 16-bit space.
// - Data falling while clock high is a start; begin a new transfer.
// - Data rising while clock high is a stop; end the transfer.
// - Transmitter changes data only while the clock is low.
// - Bytes are eight bits, MSB first, then one acknowledge slot.
// - Receiver acknowledges by pulling data low on the ninth pulse.
// - First byte is seven address bits then direction, 0 write, 1 read.
// - Acknowledge only a matching address; else idle until next start.
// - Write: two bytes after address form the register pointer, high first.
// - Unlimited data bytes per write; they are stored as register data.
// - Read: drive register bytes after the acknowledged address, one per nine pulses.
// - Master not-acknowledge ends a read; device releases the data line.
// - A repeated start begins a new addressed transfer.
// - Start or stop anywhere; a partial byte is discarded.
// - Port keeps answering while the chip is in pin power-down.
// - Address-only write loads the pointer without writing data.
// - Read without address phase starts at the current pointer.
// - Writes land in a shadow buffer, committed by the update bit.
module two_wire_config_port_slave #(
   parameter int AW = 10
) (
   input wire logic clock,                      // System clock, 25 MHz.
   input wire logic resetn,                     // Asynchronous reset, active low.
   input wire logic link_clock,                 // Link sampling clock.
   input wire logic scl_i,                      // Serial clock line level.
   input wire logic sda_i,                      // Serial data line level.
   output logic sda_o,                          // Serial data drive value, always low.
   output logic sda_oe,                         // High while pulling data low.
   input wire cfg_pkg::strap_t straps,          // Upper and lower strap level codes.
   input wire logic chip_sleep_n,               // Chip power-down pin, active low.
   output logic spi_select,                     // High when the four-wire port is chosen.
   output logic sleep_active,                   // High while the chip is powered down.
   input wire logic [15:0] cfg_addr,            // Active register lookup address.
   output logic [7:0] cfg_data                  // Active register byte.
);
   import cfg_pkg::*;

   // System domain.
   strap_t strap_s;
   strap_t strap_reg;
   logic [1:0] settle_reg;
   logic strap_done_reg;
   logic [6:0] slave_addr_reg;
   logic i2c_en_reg;
   logic sleep_s;
   logic req_tog_s;
   logic req_seen_reg;
   logic ack_tog_reg;
   logic [7:0] rd_hold_reg;
   logic [7:0] rd_data;
   logic req_new;
   logic wr_en;
   logic [3:0] strap_idx;

   // Link domain.
   logic lrst1_reg;
   logic link_rstn;
   line_t line_s;
   line_t line_d_reg;
   logic [7:0] cfg_s;
   logic ack_tog_s;
   logic ack_seen_reg;
   logic [7:0] tx_hold_reg;
   state_t state_reg;
   logic [3:0] bit_cnt_reg;
   logic [1:0] byte_cnt_reg;
   logic [7:0] shift_reg;
   logic rw_reg;
   logic [15:0] ptr_reg;
   req_t req_reg;
   logic req_tog_reg;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic byte_done;
   logic addr_hit;

   // ---- System domain: straps, sleep and the register store ----
   level_sync #(.W(4)) u_strap_sync (
      .clock(clock),
      .resetn(resetn),
      .d(straps),
      .q(strap_s)
   );

   level_sync #(.W(1)) u_sleep_sync (
      .clock(clock),
      .resetn(resetn),
      .d(chip_sleep_n),
      .q(sleep_s)
   );

   // Straps are caught once, a few cycles after reset release.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         settle_reg <= 2'h0;
         strap_done_reg <= 1'b0;
         strap_reg <= '0;
      end else if (!strap_done_reg) begin
         settle_reg <= settle_reg + 2'h1;
         if (settle_reg == STRAP_SETTLE) begin
            strap_done_reg <= 1'b1;
            strap_reg <= strap_s;
         end
      end
   end

   assign strap_idx = 4'({2'h0, strap_reg.upper} * 4'h3 + {2'h0, strap_reg.lower});

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         spi_select <= 1'b0;
         i2c_en_reg <= 1'b0;
         slave_addr_reg <= 7'h00;
      end else begin
         spi_select <= strap_done_reg && strap_reg.upper == STRAP_HIGH && strap_reg.lower == STRAP_HIGH;
         i2c_en_reg <= strap_done_reg && slave_addr_reg[2:0] == strap_idx[2:0] && strap_idx != 4'h8;
         slave_addr_reg <= {ADDR_FIXED, strap_idx[2:0]};
      end
   end

   // Power-down is only reported; the port keeps serving commands.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) sleep_active <= 1'b0;
      else sleep_active <= !sleep_s;
   end

   // Request handshake: the link toggles, the system side serves and toggles back.
   level_sync #(.W(1)) u_req_sync (
      .clock(clock),
      .resetn(resetn),
      .d(req_tog_reg),
      .q(req_tog_s)
   );

   assign req_new = req_tog_s != req_seen_reg;
   assign wr_en = req_new && req_reg.write;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         req_seen_reg <= 1'b0;
         ack_tog_reg <= 1'b0;
         rd_hold_reg <= 8'h00;
      end else if (req_new) begin
         req_seen_reg <= req_tog_s;
         ack_tog_reg <= !ack_tog_reg;
         if (!req_reg.write) rd_hold_reg <= rd_data;
      end
   end

   config_store #(.AW(AW)) u_store (
      .clock(clock),
      .resetn(resetn),
      .wr_en(wr_en),
      .wr_addr(req_reg.addr),
      .wr_data(req_reg.data),
      .rd_addr(req_reg.addr),
      .rd_data(rd_data),
      .cfg_addr(cfg_addr),
      .cfg_data(cfg_data)
   );

   // ---- Link domain ----
   always_ff @(posedge link_clock or negedge resetn) begin
      if (!resetn) begin
         lrst1_reg <= 1'b0;
         link_rstn <= 1'b0;
      end else begin
         lrst1_reg <= 1'b1;
         link_rstn <= lrst1_reg;
      end
   end

   level_sync #(.W(2)) u_line_sync (
      .clock(link_clock),
      .resetn(link_rstn),
      .d({scl_i, sda_i}),
      .q(line_s)
   );

   level_sync #(.W(8)) u_cfg_sync (
      .clock(link_clock),
      .resetn(link_rstn),
      .d({i2c_en_reg, slave_addr_reg}),
      .q(cfg_s)
   );

   level_sync #(.W(1)) u_ack_sync (
      .clock(link_clock),
      .resetn(link_rstn),
      .d(ack_tog_reg),
      .q(ack_tog_s)
   );

   always_ff @(posedge link_clock or negedge link_rstn) begin
      if (!link_rstn) line_d_reg <= '0;
      else line_d_reg <= line_s;
   end

   // Oversampling at many link clocks per serial bit serves both bus rates.
   assign scl_rise = line_s.scl && !line_d_reg.scl;
   assign scl_fall = !line_s.scl && line_d_reg.scl;
   assign start_cond = line_s.scl && line_d_reg.scl && line_d_reg.sda && !line_s.sda;
   assign stop_cond = line_s.scl && line_d_reg.scl && !line_d_reg.sda && line_s.sda;
   assign byte_done = state_reg == ST_RECV && scl_fall && bit_cnt_reg == BITS_PER_BYTE;
   assign addr_hit = cfg_s[7] && shift_reg[7:1] == cfg_s[6:0];

   // Read data returned by the system side is held for the next byte.
   always_ff @(posedge link_clock or negedge link_rstn) begin
      if (!link_rstn) begin
         ack_seen_reg <= 1'b0;
         tx_hold_reg <= 8'h00;
      end else begin
         ack_seen_reg <= ack_tog_s;
         if (ack_tog_s != ack_seen_reg) tx_hold_reg <= rd_hold_reg;
      end
   end

   // The serial clock is never driven; only the data line is pulled low.
   always_ff @(posedge link_clock or negedge link_rstn) begin
      if (!link_rstn) sda_o <= 1'b0;
      else sda_o <= 1'b0;
   end

   always_ff @(posedge link_clock or negedge link_rstn) begin
      if (!link_rstn) begin
         state_reg <= ST_IDLE;
         bit_cnt_reg <= 4'h0;
         byte_cnt_reg <= BYTE_SLAVE;
         shift_reg <= 8'h00;
         rw_reg <= 1'b0;
         ptr_reg <= 16'h0000;
         sda_oe <= 1'b0;
         req_reg <= '0;
         req_tog_reg <= 1'b0;
      end else if (start_cond) begin
         // A new or repeated start drops any partial byte.
         state_reg <= ST_RECV;
         bit_cnt_reg <= 4'h0;
         byte_cnt_reg <= BYTE_SLAVE;
         sda_oe <= 1'b0;
      end else if (stop_cond) begin
         state_reg <= ST_IDLE;
         sda_oe <= 1'b0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
            end
            ST_RECV: begin
               if (scl_rise && bit_cnt_reg < BITS_PER_BYTE) begin
                  shift_reg <= {shift_reg[6:0], line_s.sda};
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end else if (byte_done) begin
                  if (byte_cnt_reg != BYTE_DATA) byte_cnt_reg <= byte_cnt_reg + 2'h1;
                  unique case (byte_cnt_reg)
                     BYTE_SLAVE: begin
                        if (addr_hit) begin
                           sda_oe <= 1'b1;
                           rw_reg <= shift_reg[0];
                           state_reg <= ST_ACK;
                           if (shift_reg[0]) begin
                              req_reg <= '{write: 1'b0, addr: ptr_reg, data: 8'h00};
                              req_tog_reg <= !req_tog_reg;
                           end
                        end else begin
                           state_reg <= ST_IDLE;
                        end
                     end
                     BYTE_PTR_HI: begin
                        ptr_reg[15:8] <= shift_reg;
                        sda_oe <= 1'b1;
                        state_reg <= ST_ACK;
                     end
                     BYTE_PTR_LO: begin
                        ptr_reg[7:0] <= shift_reg;
                        sda_oe <= 1'b1;
                        state_reg <= ST_ACK;
                     end
                     BYTE_DATA: begin
                        req_reg <= '{write: 1'b1, addr: ptr_reg, data: shift_reg};
                        req_tog_reg <= !req_tog_reg;
                        ptr_reg <= ptr_reg + 16'h0001;
                        sda_oe <= 1'b1;
                        state_reg <= ST_ACK;
                     end
                  endcase
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  if (rw_reg) begin
                     // First read bit goes out in the same low phase that ends the acknowledge.
                     sda_oe <= !tx_hold_reg[7];
                     shift_reg <= {tx_hold_reg[6:0], 1'b0};
                     bit_cnt_reg <= 4'h1;
                     state_reg <= ST_SEND;
                  end else begin
                     sda_oe <= 1'b0;
                     bit_cnt_reg <= 4'h0;
                     state_reg <= ST_RECV;
                  end
               end
            end
            ST_SEND: begin
               if (scl_fall) begin
                  if (bit_cnt_reg == BITS_PER_BYTE) begin
                     // Byte sent: release for the master's acknowledge and fetch the next byte.
                     sda_oe <= 1'b0;
                     state_reg <= ST_WACK;
                     ptr_reg <= ptr_reg + 16'h0001;
                     req_reg <= '{write: 1'b0, addr: ptr_reg + 16'h0001, data: 8'h00};
                     req_tog_reg <= !req_tog_reg;
                  end else begin
                     sda_oe <= !shift_reg[7];
                     shift_reg <= {shift_reg[6:0], 1'b0};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end
               end
            end
            ST_WACK: begin
               if (scl_rise && line_s.sda) begin
                  state_reg <= ST_IDLE;
               end else if (scl_fall) begin
                  sda_oe <= !tx_hold_reg[7];
                  shift_reg <= {tx_hold_reg[6:0], 1'b0};
                  bit_cnt_reg <= 4'h1;
                  state_reg <= ST_SEND;
               end
            end
         endcase
      end
   end

   // ---- Checks ----
   property p_start_begins;
      @(posedge link_clock) disable iff (!link_rstn)
      start_cond |=> state_reg == ST_RECV && bit_cnt_reg == 4'h0 && byte_cnt_reg == BYTE_SLAVE && !sda_oe;
   endproperty
   a_start_begins: assert property (p_start_begins)
      else $error("start did not open a fresh transfer");

   property p_stop_ends;
      @(posedge link_clock) disable iff (!link_rstn)
      (stop_cond && !start_cond) |=> state_reg == ST_IDLE && !sda_oe;
   endproperty
   a_stop_ends: assert property (p_stop_ends)
      else $error("stop did not end the transfer");

   property p_miss_stays_idle;
      @(posedge link_clock) disable iff (!link_rstn)
      (byte_done && !start_cond && !stop_cond && byte_cnt_reg == BYTE_SLAVE && !addr_hit)
         |=> (state_reg == ST_IDLE && !sda_oe) [*2];
   endproperty
   a_miss_stays_idle: assert property (p_miss_stays_idle)
      else $error("foreign address was answered");

   property p_hit_acks;
      @(posedge link_clock) disable iff (!link_rstn)
      (byte_done && !start_cond && !stop_cond && addr_hit) |=> sda_oe && state_reg == ST_ACK;
   endproperty
   a_hit_acks: assert property (p_hit_acks)
      else $error("own address not acknowledged");

   property p_nack_releases;
      @(posedge link_clock) disable iff (!link_rstn)
      (state_reg == ST_WACK && scl_rise && line_s.sda && !start_cond && !stop_cond)
         |=> state_reg == ST_IDLE && !sda_oe;
   endproperty
   a_nack_releases: assert property (p_nack_releases)
      else $error("data line held after not-acknowledge");

   property p_drive_changes_low;
      @(posedge link_clock) disable iff (!link_rstn)
      $rose(sda_oe) |-> !line_s.scl && $past(scl_fall);
   endproperty
   a_drive_changes_low: assert property (p_drive_changes_low)
      else $error("data drive changed outside clock low");

   property p_byte_len;
      @(posedge link_clock) disable iff (!link_rstn)
      bit_cnt_reg <= BITS_PER_BYTE;
   endproperty
   a_byte_len: assert property (p_byte_len)
      else $error("bit count passed eight");

   property p_ptr_step;
      @(posedge link_clock) disable iff (!link_rstn)
      (byte_done && !start_cond && !stop_cond && byte_cnt_reg == BYTE_DATA)
         |=> ptr_reg == $past(ptr_reg) + 16'h0001 && req_reg.write && req_reg.data == $past(shift_reg);
   endproperty
   a_ptr_step: assert property (p_ptr_step)
      else $error("pointer did not advance after data byte");

   property p_port_choice;
      @(posedge clock) disable iff (!resetn)
      $rose(strap_done_reg) |-> ##2 spi_select != i2c_en_reg
         && slave_addr_reg[6:3] == ADDR_FIXED;
   endproperty
   a_port_choice: assert property (p_port_choice)
      else $error("port selection inconsistent");

   c_read_end: cover property (@(posedge link_clock) disable iff (!link_rstn)
      state_reg == ST_WACK ##1 state_reg == ST_IDLE);
   c_data_write: cover property (@(posedge link_clock) disable iff (!link_rstn)
      byte_done && byte_cnt_reg == BYTE_DATA);
   c_repeat_start: cover property (@(posedge link_clock) disable iff (!link_rstn)
      state_reg == ST_ACK ##[1:200] start_cond);
   c_update: cover property (@(posedge clock) disable iff (!resetn)
      wr_en && req_reg.addr == UPDATE_ADDR);
endmodule

// [sim/i2c_master_model.sv]
// Two-wire bus master model that makes every clock pulse and resolves the open-drain data line.
module i2c_master_model (
   output logic scl,         // Serial clock, driven only by this master.
   output wire sda,          // Resolved data line level, pulled up.
   input wire logic dut_oe,  // Device drive enable.
   input wire logic dut_o    // Device drive value; a one leaves the line to the pull-up.
);
   timeunit 1ns;
   timeprecision 100ps;
   int q = 625;
   logic pull = 1'b0;
   // The line floats high through the pull-up unless some party pulls it low.
   assign sda = ~pull & (~dut_oe | dut_o);
   initial scl = 1'b1;
   task automatic bit_io(input logic b, output logic r);
      pull = ~b;
      #q;
      scl = 1'b1;
      #q;
      r = sda;
      #q;
      scl = 1'b0;
      #q;
   endtask
   task automatic start();
      pull = 1'b0;
      #q;
      scl = 1'b1;
      #q;
      pull = 1'b1;
      #q;
      scl = 1'b0;
      #q;
   endtask
   task automatic stop();
      pull = 1'b1;
      #q;
      scl = 1'b1;
      #q;
      pull = 1'b0;
      #q;
   endtask
   task automatic wr(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(b[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   task automatic rd(input logic ack, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         b[i] = r;
      end
      bit_io(~ack, r);
   endtask
endmodule

// [sim/tb_two_wire_config_port_slave.sv]
// Self-checking bench for the two-wire configuration port slave.
module tb_two_wire_config_port_slave;
   timeunit 1ns;
   timeprecision 100ps;
   import cfg_pkg::*;
   logic clock = 1'b0;
   logic link_clock = 1'b0;
   logic resetn = 1'b0;
   wire scl;
   wire sda;
   logic sda_oe;
   logic sda_o;
   logic spi_select;
   logic sleep_active;
   strap_t straps = '0;
   logic chip_sleep_n = 1'b1;
   logic [15:0] cfg_addr = 16'h0000;
   logic [7:0] cfg_data;
   int bad_count = 0;
   int n_tests = 0;
   two_wire_config_port_slave #(.AW(10)) dut_u (.clock(clock), .resetn(resetn), .link_clock(link_clock),
      .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .straps(straps), .chip_sleep_n(chip_sleep_n),
      .spi_select(spi_select), .sleep_active(sleep_active), .cfg_addr(cfg_addr), .cfg_data(cfg_data));
   i2c_master_model mst_u (.scl(scl), .sda(sda), .dut_oe(sda_oe), .dut_o(sda_o));
   initial forever #20 clock = ~clock;
   initial begin
      #17;
      forever #62.5 link_clock = ~link_clock;
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Reset is held long enough to cover three link clock edges.
   task automatic do_reset(input strap_t s);
      @(posedge clock);
      resetn <= 1'b0;
      straps <= s;
      repeat (10) @(posedge clock);
      resetn <= 1'b1;
      repeat (40) @(posedge clock);
   endtask
   task automatic send(input logic [7:0] b);
      logic a;
      mst_u.wr(b, a);
      check(8'(a), 8'h01);
   endtask
   task automatic strap_sweep();
      logic a;
      for (int u = 0; u < 3; u++) begin
         for (int l = 0; l < 3; l++) begin
            do_reset({u[1:0], l[1:0]});
            check(8'(spi_select), 8'(u == 2 && l == 2));
            mst_u.start();
            mst_u.wr({ADDR_FIXED, 3'(u * 3 + l), 1'b0}, a);
            mst_u.stop();
            check(8'(a), 8'(u * 3 + l < 8));
            mst_u.start();
            mst_u.wr({ADDR_FIXED, 3'(u * 3 + l + 1), 1'b0}, a);
            mst_u.stop();
            check(8'(a), 8'h00);
         end
      end
   endtask
   // Standard rate stream with the chip asleep: write two bytes, reload the pointer, read them back.
   task automatic stream_sleep();
      logic [7:0] d;
      @(posedge clock);
      chip_sleep_n <= 1'b0;
      mst_u.q = 2500;
      mst_u.start();
      send(8'hb0);
      send(8'h00);
      send(8'h10);
      send(8'ha5);
      send(8'h3c);
      mst_u.stop();
      check(8'(sleep_active), 8'h01);
      mst_u.start();
      send(8'hb0);
      send(8'h00);
      send(8'h10);
      mst_u.stop();
      mst_u.start();
      send(8'hb1);
      mst_u.rd(1'b1, d);
      check(d, 8'ha5);
      mst_u.rd(1'b0, d);
      check(d, 8'h3c);
      mst_u.stop();
      check(8'(sda), 8'h01);
      @(posedge clock);
      chip_sleep_n <= 1'b1;
   endtask
   // Fast rate: repeated start read, an aborted byte, then the update commit.
   task automatic repstart_commit();
      logic [7:0] d;
      logic b;
      mst_u.q = 625;
      @(posedge clock);
      cfg_addr <= 16'h0010;
      repeat (3) @(posedge clock);
      check(cfg_data, 8'h00);
      mst_u.start();
      send(8'hb0);
      send(8'h00);
      send(8'h11);
      mst_u.start();
      send(8'hb1);
      mst_u.rd(1'b0, d);
      mst_u.stop();
      check(d, 8'h3c);
      mst_u.start();
      send(8'hb0);
      send(8'h00);
      send(8'h10);
      repeat (4) mst_u.bit_io(1'b0, b);
      mst_u.stop();
      mst_u.start();
      send(8'hb0);
      send(8'h02);
      send(8'h32);
      send(8'h01);
      mst_u.stop();
      repeat (20) @(posedge clock);
      check(cfg_data, 8'ha5);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      strap_sweep();
      do_reset('0);
      stream_sleep();
      repstart_commit();
      conclude();
   end
   initial begin
      repeat (100000) @(posedge clock);
      bad_count++;
      $display("[FAIL] %0t run did not finish", $time);
      conclude();
   end
endmodule
